// ==== cpm_pkg.sv ====
// Behaviour
// - Follow mode and limit pins at all times, except during HID wake override.
// - Pins a=0, c=1: auto charge mode, high limit, data switches open.
// - Pins b=1, c=0: data port mode a, switches closed, limit from select.
// - Pins 100: forced short mode, limit from select, switches open.
// - Pins 101: forced divider mode, limit from select.
// - Pins 111: charging downstream port if select high, else data port mode b.
// - Swapping between those two all-high settings never starts a discharge.
// - Discharge: power switch off, rail discharged, switch on again, on mode change.
// - With HID recognised, hold 111 or 010 when pins move to 011.
// - 110 to 011 is never held; a transient 111 discharges.
// - Watch data lines only in data port or charging downstream modes.
// - D- high after both lines idle low means low-speed attach.
// - D+ high with D- low after idle means full-speed candidate.
// - D+ dropping after connect marks high-speed, never a full-speed wake source.
// - Full-speed needs 60 s connected in working mode; low-speed needs none.
// - No deadline for pins returning from auto to data-port after wake.
// - Reset holds the initial state with the output discharging.
// - Data switches open when disabled, pins 000, dedicated charging, or discharging.
package cpm_pkg;
   // ***************************************
   // Timing
   // ***************************************
   localparam int CLK_HZ = 250_000_000;
   localparam int CLK_MHZ = CLK_HZ / 1_000_000;
   localparam int FS_QUAL_TIME_S = 60;
   localparam longint FS_QUAL_CYCLES = longint'(FS_QUAL_TIME_S) * longint'(CLK_HZ);
   localparam int DISCH_TIME_US = 100;
   localparam int DISCH_CYCLES = DISCH_TIME_US * CLK_MHZ;
   localparam int DETACH_TIME_US = 10;
   localparam int DETACH_CYCLES = DETACH_TIME_US * CLK_MHZ;
   localparam int QUAL_W = 34;
   localparam int DISCH_W = 32;
   localparam int DETACH_W = 16;

   // ***************************************
   // Register map
   // ***************************************
   localparam logic [3:0] REG_CTRL_ADDR = 4'h0;
   localparam logic [3:0] REG_STATUS_ADDR = 4'h4;
   localparam int CTRL_WAKE_EN_BIT = 0;
   localparam int CTRL_CLR_HID_BIT = 1;
   localparam logic CTRL_WAKE_EN_RESET = 1'h1;
   localparam int ST_MODE_LSB = 0;
   localparam int ST_HI_BIT = 3;
   localparam int ST_DSW_BIT = 4;
   localparam int ST_PWR_BIT = 5;
   localparam int ST_DISCH_BIT = 6;
   localparam int ST_LS_BIT = 7;
   localparam int ST_FS_BIT = 8;
   localparam int ST_HS_BIT = 9;
   localparam int ST_OVR_BIT = 10;
   localparam int ST_PINS_LSB = 11;

   // ***************************************
   // Pin codes, ordered {a, b, c}
   // ***************************************
   localparam logic [2:0] PINS_OFF = 3'h0;
   localparam logic [2:0] PINS_DATA_A_LO = 3'h2;
   localparam logic [2:0] PINS_AUTO_WAKE = 3'h3;
   localparam logic [2:0] PINS_DATA_A_HI = 3'h6;
   localparam logic [2:0] PINS_ALL_HIGH = 3'h7;

   typedef enum logic [2:0] {
      MODE_DISCHARGE = 3'h0,
      MODE_AUTO = 3'h1,
      MODE_DATA_A = 3'h2,
      MODE_SHORT = 3'h3,
      MODE_DIVIDER = 3'h4,
      MODE_CHARGE_DS = 3'h5,
      MODE_DATA_B = 3'h6
   } cpm_mode_t;

   typedef enum logic [1:0] {
      ST_INIT = 2'h0,
      ST_DISCH = 2'h1,
      ST_ON = 2'h3
   } cpm_state_t;

   function automatic cpm_mode_t cpm_decode(input logic [2:0] pins, input logic lim);
      cpm_mode_t m;
      m = MODE_DISCHARGE;
      if (pins == PINS_OFF) begin
         m = MODE_DISCHARGE;
      end else if (!pins[2] && pins[0]) begin
         m = MODE_AUTO;
      end else if (pins[1] && !pins[0]) begin
         m = MODE_DATA_A;
      end else if (pins[2] && !pins[1] && !pins[0]) begin
         m = MODE_SHORT;
      end else if (pins[2] && !pins[1] && pins[0]) begin
         m = MODE_DIVIDER;
      end else begin
         m = lim ? MODE_CHARGE_DS : MODE_DATA_B;
      end
      return m;
   endfunction

   function automatic logic cpm_high_limit(input cpm_mode_t m, input logic lim);
      return (m == MODE_AUTO) ? 1'b1 : ((m == MODE_DISCHARGE) ? 1'b0 : lim);
   endfunction

   function automatic logic cpm_is_data(input cpm_mode_t m);
      return (m == MODE_DATA_A) || (m == MODE_DATA_B) || (m == MODE_CHARGE_DS);
   endfunction
endpackage

`timescale 1ns/100ps
`default_nettype none
// ***************************************
// Two-stage pin synchroniser
// ***************************************
module cpm_sync2 #(
   parameter int W = 1
) (
   // Clock and reset
   input wire logic CLOCK,
   input wire logic RST,
   // Data
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_reg;

   always_ff @(posedge CLOCK or posedge RST) begin
      if (RST) begin
         meta_reg <= '0;
         q <= '0;
      end else begin
         meta_reg <= d;
         q <= meta_reg;
      end
   end
endmodule
`default_nettype wire

// ==== cpm_mode_ctrl.sv ====
`timescale 1ns/100ps
`default_nettype none
module cpm_mode_ctrl
   import cpm_pkg::*;
#(
   parameter logic [DISCH_W-1:0] DISCH_CYC = DISCH_W'(DISCH_CYCLES),
   parameter logic [QUAL_W-1:0] QUAL_CYC = QUAL_W'(FS_QUAL_CYCLES)
) (
   // Clock and reset
   input wire logic CLOCK,
   input wire logic RST,
   // Mode pins
   input wire logic ENABLE,
   input wire logic MODE_PIN_A,
   input wire logic MODE_PIN_B,
   input wire logic MODE_PIN_C,
   input wire logic LIMIT_SELECT,
   // Data line comparators
   input wire logic DP_HIGH,
   input wire logic DM_HIGH,
   // Power path and switches
   output logic POWER_SWITCH_ON,
   output logic DISCHARGE_ON,
   output logic DATA_SWITCH_ON,
   output logic HIGH_LIMIT_SEL,
   output logic [2:0] MODE,
   output logic HID_RECOGNISED,
   // Avalon-MM slave
   input wire logic [3:0] AVS_ADDRESS,
   input wire logic AVS_READ,
   input wire logic AVS_WRITE,
   input wire logic [31:0] AVS_WRITEDATA,
   input wire logic [3:0] AVS_BYTEENABLE,
   output logic [31:0] AVS_READDATA,
   output logic AVS_WAITREQUEST
);
   // ***************************************
   // Pin synchronisation
   // ***************************************
   logic en_s, a_s, b_s, c_s, lim_s, dp_s, dm_s;

   cpm_sync2 #(.W(7)) u_sync (
      .CLOCK(CLOCK),
      .RST(RST),
      .d({ENABLE, MODE_PIN_A, MODE_PIN_B, MODE_PIN_C, LIMIT_SELECT, DP_HIGH, DM_HIGH}),
      .q({en_s, a_s, b_s, c_s, lim_s, dp_s, dm_s})
   );

   logic [2:0] pins;
   cpm_mode_t cmd_mode;
   logic cmd_hi;
   assign pins = {a_s, b_s, c_s};
   assign cmd_mode = cpm_decode(pins, lim_s);
   assign cmd_hi = cpm_high_limit(cmd_mode, lim_s);

   // ***************************************
   // Mode sequencer
   // ***************************************
   cpm_state_t state_reg, state_next;
   cpm_mode_t applied_reg, applied_next;
   logic [2:0] apins_reg, apins_next;
   logic ahi_reg, ahi_next;
   logic [DISCH_W-1:0] dcnt_reg, dcnt_next;
   logic wake_en_reg, wake_en_next;
   logic hid_rec;
   logic override;
   logic swap;

   // Pin history, wake enable and HID recognition decide; limit select plays no part here
   assign override = wake_en_reg && hid_rec && (state_reg == ST_ON) && (pins == PINS_AUTO_WAKE)
      && ((apins_reg == PINS_ALL_HIGH) || (apins_reg == PINS_DATA_A_LO));
   assign swap = ((applied_reg == MODE_CHARGE_DS) || (applied_reg == MODE_DATA_B))
      && ((cmd_mode == MODE_CHARGE_DS) || (cmd_mode == MODE_DATA_B));

   always_comb begin
      state_next = state_reg;
      applied_next = applied_reg;
      apins_next = apins_reg;
      ahi_next = ahi_reg;
      dcnt_next = dcnt_reg;
      unique case (state_reg)
         ST_INIT: begin
            state_next = ST_DISCH;
            dcnt_next = '0;
         end
         ST_DISCH: begin
            applied_next = cmd_mode;
            apins_next = pins;
            ahi_next = cmd_hi;
            // Pins 000 keep the rail held low indefinitely
            if (cmd_mode == MODE_DISCHARGE) begin
               dcnt_next = '0;
            end else if (dcnt_reg == DISCH_CYC - 1'b1) begin
               state_next = ST_ON;
               dcnt_next = '0;
            end else begin
               dcnt_next = dcnt_reg + 1'b1;
            end
         end
         ST_ON: begin
            // Held with no time limit while the wake device stays attached
            if (override) begin
               state_next = ST_ON;
            end else if (cmd_mode == applied_reg) begin
               apins_next = pins;
               ahi_next = cmd_hi;
            end else if (swap) begin
               applied_next = cmd_mode;
               apins_next = pins;
               ahi_next = cmd_hi;
            end else begin
               state_next = ST_DISCH;
               dcnt_next = '0;
               applied_next = cmd_mode;
               apins_next = pins;
               ahi_next = cmd_hi;
            end
         end
         default: begin
            state_next = ST_INIT;
         end
      endcase
   end

   always_ff @(posedge CLOCK or posedge RST) begin
      if (RST) begin
         state_reg <= ST_INIT;
         applied_reg <= MODE_DISCHARGE;
         apins_reg <= PINS_OFF;
         ahi_reg <= 1'b0;
         dcnt_reg <= '0;
      end else begin
         state_reg <= state_next;
         applied_reg <= applied_next;
         apins_reg <= apins_next;
         ahi_reg <= ahi_next;
         dcnt_reg <= dcnt_next;
      end
   end

   // ***************************************
   // Low/full-speed device recognition
   // ***************************************
   logic monitor;
   logic clr_hid;
   logic idle_reg, idle_next;
   logic ls_reg, ls_next;
   logic fs_reg, fs_next;
   logic hs_reg, hs_next;
   logic [QUAL_W-1:0] qcnt_reg, qcnt_next;
   logic [DETACH_W-1:0] det_reg, det_next;

   assign monitor = (state_reg == ST_ON) && cpm_is_data(applied_reg);
   assign hid_rec = ls_reg || fs_reg;

   always_comb begin
      idle_next = idle_reg;
      ls_next = ls_reg;
      fs_next = fs_reg;
      hs_next = hs_reg;
      qcnt_next = qcnt_reg;
      det_next = det_reg;
      if (!monitor || clr_hid) begin
         idle_next = 1'b0;
         ls_next = 1'b0;
         fs_next = 1'b0;
         hs_next = 1'b0;
         qcnt_next = '0;
         det_next = '0;
      end else if (!dp_s && !dm_s) begin
         idle_next = 1'b1;
         // A candidate losing D+ is a high-speed device negotiating
         if (!fs_reg && (qcnt_reg != '0)) begin
            hs_next = 1'b1;
            qcnt_next = '0;
         end
         if (det_reg == DETACH_W'(DETACH_CYCLES - 1)) begin
            ls_next = 1'b0;
            fs_next = 1'b0;
            qcnt_next = '0;
         end else begin
            det_next = det_reg + 1'b1;
         end
      end else begin
         det_next = '0;
         if (idle_reg && dm_s && !dp_s) begin
            ls_next = 1'b1;
         end
         if (idle_reg && dp_s && !dm_s && !hs_reg && !fs_reg) begin
            if (qcnt_reg == QUAL_CYC - 1'b1) begin
               fs_next = 1'b1;
            end else begin
               qcnt_next = qcnt_reg + 1'b1;
            end
         end
      end
   end

   always_ff @(posedge CLOCK or posedge RST) begin
      if (RST) begin
         idle_reg <= 1'b0;
         ls_reg <= 1'b0;
         fs_reg <= 1'b0;
         hs_reg <= 1'b0;
         qcnt_reg <= '0;
         det_reg <= '0;
      end else begin
         idle_reg <= idle_next;
         ls_reg <= ls_next;
         fs_reg <= fs_next;
         hs_reg <= hs_next;
         qcnt_reg <= qcnt_next;
         det_reg <= det_next;
      end
   end

   // ***************************************
   // Registered outputs
   // ***************************************
   logic pwr_next, disch_next, dsw_next, ovr_next, ovr_reg;

   always_comb begin
      pwr_next = (state_next == ST_ON);
      disch_next = (state_next != ST_ON);
      dsw_next = (state_next == ST_ON) && en_s && cpm_is_data(applied_next);
      ovr_next = override;
   end

   always_ff @(posedge CLOCK or posedge RST) begin
      if (RST) begin
         POWER_SWITCH_ON <= 1'b0;
         DISCHARGE_ON <= 1'b1;
         DATA_SWITCH_ON <= 1'b0;
         HIGH_LIMIT_SEL <= 1'b0;
         MODE <= MODE_DISCHARGE;
         HID_RECOGNISED <= 1'b0;
         ovr_reg <= 1'b0;
      end else begin
         POWER_SWITCH_ON <= pwr_next;
         DISCHARGE_ON <= disch_next;
         DATA_SWITCH_ON <= dsw_next;
         HIGH_LIMIT_SEL <= ahi_next;
         MODE <= applied_next;
         HID_RECOGNISED <= ls_next || fs_next;
         ovr_reg <= ovr_next;
      end
   end

   // ***************************************
   // Avalon-MM register slave
   // ***************************************
   logic wait_next;
   logic [31:0] rdata_next;
   logic accept;
   logic [31:0] status;

   // One wait cycle per access; the answer stands when waitrequest drops
   assign accept = (AVS_READ || AVS_WRITE) && !AVS_WAITREQUEST;
   assign clr_hid = accept && AVS_WRITE && (AVS_ADDRESS == REG_CTRL_ADDR)
      && AVS_BYTEENABLE[0] && AVS_WRITEDATA[CTRL_CLR_HID_BIT];

   always_comb begin
      status = '0;
      status[ST_MODE_LSB +: 3] = applied_reg;
      status[ST_HI_BIT] = ahi_reg;
      status[ST_DSW_BIT] = DATA_SWITCH_ON;
      status[ST_PWR_BIT] = POWER_SWITCH_ON;
      status[ST_DISCH_BIT] = DISCHARGE_ON;
      status[ST_LS_BIT] = ls_reg;
      status[ST_FS_BIT] = fs_reg;
      status[ST_HS_BIT] = hs_reg;
      status[ST_OVR_BIT] = ovr_reg;
      status[ST_PINS_LSB +: 3] = pins;
      wait_next = !((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST);
      rdata_next = AVS_READDATA;
      wake_en_next = wake_en_reg;
      if (AVS_READ && AVS_WAITREQUEST) begin
         rdata_next = '0;
         if (AVS_ADDRESS == REG_CTRL_ADDR) begin
            rdata_next[CTRL_WAKE_EN_BIT] = wake_en_reg;
         end else if (AVS_ADDRESS == REG_STATUS_ADDR) begin
            rdata_next = status;
         end
      end
      if (accept && AVS_WRITE && (AVS_ADDRESS == REG_CTRL_ADDR) && AVS_BYTEENABLE[0]) begin
         wake_en_next = AVS_WRITEDATA[CTRL_WAKE_EN_BIT];
      end
   end

   always_ff @(posedge CLOCK or posedge RST) begin
      if (RST) begin
         AVS_WAITREQUEST <= 1'b1;
         AVS_READDATA <= '0;
         wake_en_reg <= CTRL_WAKE_EN_RESET;
      end else begin
         AVS_WAITREQUEST <= wait_next;
         AVS_READDATA <= rdata_next;
         wake_en_reg <= wake_en_next;
      end
   end

   // ***************************************
   // Assertions
   // ***************************************
   default clocking cb @(posedge CLOCK);
   endclocking
   default disable iff (RST);

   property p_auto_limit;
      (state_next == ST_ON) && (applied_next == MODE_AUTO) |=> HIGH_LIMIT_SEL && !DATA_SWITCH_ON;
   endproperty
   a_auto_limit: assert property (p_auto_limit) else $error("auto mode limit or switch wrong");

   property p_data_a;
      (state_next == ST_ON) && (applied_next == MODE_DATA_A) |=> MODE == MODE_DATA_A;
   endproperty
   a_data_a: assert property (p_data_a) else $error("data port a not reported");

   property p_short_limit;
      (state_reg == ST_DISCH) && (pins == 3'h4) && (dcnt_reg == DISCH_CYC - 1'b1)
         |=> ##1 (MODE == MODE_SHORT) && (HIGH_LIMIT_SEL == $past(lim_s, 2)) && !DATA_SWITCH_ON;
   endproperty
   a_short_limit: assert property (p_short_limit) else $error("forced short mode wrong");

   property p_no_disch_swap;
      (state_reg == ST_ON) && swap && !override |=> state_reg == ST_ON;
   endproperty
   a_no_disch_swap: assert property (p_no_disch_swap) else $error("swap caused discharge");

   property p_disch_cycle;
      (state_reg == ST_ON) && !override && !swap && (cmd_mode != applied_reg)
         |=> (state_reg == ST_DISCH) ##1 (DISCHARGE_ON && !POWER_SWITCH_ON);
   endproperty
   a_disch_cycle: assert property (p_disch_cycle) else $error("mode change missed discharge");

   property p_override_hold;
      override |=> $stable(applied_reg) && (state_reg == ST_ON);
   endproperty
   a_override_hold: assert property (p_override_hold) else $error("override lost mode");

   property p_no_ovr_110;
      (state_reg == ST_ON) && (apins_reg == PINS_DATA_A_HI) && (pins == PINS_AUTO_WAKE)
         |=> state_reg == ST_DISCH;
   endproperty
   a_no_ovr_110: assert property (p_no_ovr_110) else $error("110 to 011 was held");

   property p_monitor_gate;
      !monitor |=> !ls_reg && !fs_reg && !hs_reg;
   endproperty
   a_monitor_gate: assert property (p_monitor_gate) else $error("detection outside data mode");

   property p_hs_block;
      hs_reg |-> !fs_reg;
   endproperty
   a_hs_block: assert property (p_hs_block) else $error("high-speed taken as full-speed");

   property p_switch_open;
      (state_reg != ST_ON) |-> !DATA_SWITCH_ON && !POWER_SWITCH_ON;
   endproperty
   a_switch_open: assert property (p_switch_open) else $error("switch closed while off");

   property p_init_disch;
      (state_reg == ST_INIT) |-> DISCHARGE_ON ##1 (state_reg == ST_DISCH);
   endproperty
   a_init_disch: assert property (p_init_disch) else $error("init not discharging");

   c_discharge: cover property ((state_reg == ST_ON) ##1 (state_reg == ST_DISCH));
   c_override: cover property (override [*3]);
   c_fs_rec: cover property ($rose(fs_reg));
   c_ls_rec: cover property ($rose(ls_reg));
endmodule
`default_nettype wire

// ==== cpm_usb_dev.sv ====
`timescale 1ns/100ps
`default_nettype none
// ***************************************
// Attached USB device, comparator view
// ***************************************
module cpm_usb_dev (
   // Clock
   input wire logic clock,
   // Kind: 0 none, 1 low speed, 2 full speed, 3 high speed
   input wire logic [1:0] kind,
   // Line comparators
   output logic dp_high,
   output logic dm_high
);
   logic [3:0] hs_cnt = 4'h0;

   always_ff @(posedge clock) begin
      if (kind != 2'h3) begin
         hs_cnt <= 4'h0;
      end else if (hs_cnt != 4'hF) begin
         hs_cnt <= hs_cnt + 4'h1;
      end
   end

   // Pull-downs hold both lines low with nothing attached
   always_comb begin
      dm_high = (kind == 2'h1);
      // High speed drops its pull-up soon after connect, then idles low
      dp_high = (kind == 2'h2) || (kind == 2'h3 && hs_cnt < 4'h6);
   end
endmodule
`default_nettype wire

// ==== tb_top.sv ====
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin error_cnt++; $display("wrong value %s expected %h seen %h", nm, e, g); end end
module tb_top;
   import cpm_pkg::*;
   // Short counts keep the run brief
   localparam int DCYC = 8;
   localparam int QCYC = 50;
   typedef struct {string nm; logic [31:0] e; logic [31:0] m;} cpm_note_t;
   logic clock = 1'b0;
   logic rst = 1'b1;
   logic en = 1'b1;
   logic pa = 1'b0;
   logic pb = 1'b0;
   logic pc = 1'b0;
   logic lim = 1'b0;
   logic [3:0] addr = 4'h0;
   logic rd = 1'b0;
   logic wr = 1'b0;
   logic [31:0] wdata = 32'h0;
   logic [1:0] dev_kind = 2'h0;
   logic dp, dm, pwr, dis, dsw, hi, hid, avs_wait;
   logic [2:0] mode;
   logic [31:0] rdata;
   int error_cnt = 0;
   int cmp_count = 0;
   int seed = 3875;
   cpm_note_t notes[$];
   event chk_ev;
   wire logic [7:0] obs;
   assign obs = {hid, dis, pwr, dsw, hi, mode};

   initial begin
      forever #2 clock = ~clock;
   end

   cpm_usb_dev dev (.clock(clock), .kind(dev_kind), .dp_high(dp), .dm_high(dm));

   cpm_mode_ctrl #(.DISCH_CYC(DISCH_W'(DCYC)), .QUAL_CYC(QUAL_W'(QCYC))) uut (
      .CLOCK(clock), .RST(rst), .ENABLE(en), .MODE_PIN_A(pa), .MODE_PIN_B(pb),
      .MODE_PIN_C(pc), .LIMIT_SELECT(lim), .DP_HIGH(dp), .DM_HIGH(dm),
      .POWER_SWITCH_ON(pwr), .DISCHARGE_ON(dis), .DATA_SWITCH_ON(dsw),
      .HIGH_LIMIT_SEL(hi), .MODE(mode), .HID_RECOGNISED(hid), .AVS_ADDRESS(addr),
      .AVS_READ(rd), .AVS_WRITE(wr), .AVS_WRITEDATA(wdata), .AVS_BYTEENABLE(4'hF),
      .AVS_READDATA(rdata), .AVS_WAITREQUEST(avs_wait));

   // ***************************************
   // Expectations and monitor
   // ***************************************
   function automatic logic [7:0] want(logic [3:0] v, logic e);
      logic [2:0] m;
      logic h, d;
      h = v[0];
      d = 1'b0;
      case (v[3:1])
         3'h0: begin m = 3'h0; h = 1'b0; end
         3'h1, 3'h3: begin m = 3'h1; h = 1'b1; end
         3'h2, 3'h6: begin m = 3'h2; d = e; end
         3'h4: m = 3'h3;
         3'h5: m = 3'h4;
         default: begin m = v[0] ? 3'h5 : 3'h6; d = e; end
      endcase
      return {1'b0, v[3:1] == 3'h0, v[3:1] != 3'h0, d, h, m};
   endfunction

   task automatic note(string nm, logic [31:0] e, logic [31:0] m);
      notes.push_back('{nm, e, m});
   endtask

   task automatic check_out(logic [31:0] g);
      cpm_note_t n;
      if (notes.size() == 0) begin
         error_cnt++;
         $display("wrong value note queue expected entry seen none");
      end else begin
         n = notes.pop_front();
         `CHK(n.nm, n.e & n.m, g & n.m)
      end
   endtask

   always @(chk_ev) check_out({24'h0, obs});
   always @(posedge clock) if (rd === 1'b1 && avs_wait === 1'b0) check_out(rdata);

   // ***************************************
   // Drivers
   // ***************************************
   task automatic cyc(int n);
      repeat (n) @(posedge clock);
   endtask

   task automatic look(logic [7:0] e, logic [7:0] m);
      @(negedge clock);
      note("outputs", {24'h0, e}, {24'h0, m});
      ->chk_ev;
   endtask

   task automatic pins(logic [3:0] v);
      @(posedge clock);
      {pa, pb, pc, lim} <= v;
   endtask

   // Holds the request until waitrequest is sampled low
   task automatic bus(logic w, logic [3:0] a, logic [31:0] d);
      int n;
      n = 0;
      @(posedge clock);
      rd <= !w;
      wr <= w;
      addr <= a;
      wdata <= d;
      do begin
         @(posedge clock);
         n++;
      end while (avs_wait !== 1'b0 && n < 50);
      rd <= 1'b0;
      wr <= 1'b0;
      if (n >= 50) `CHK("waitrequest", 1'b0, avs_wait)
   endtask

   task automatic finish_test();
      $display("counts: %0d compared, %0d wrong", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   initial begin
      #120_000;
      error_cnt++;
      $display("watchdog ran out");
      finish_test();
   end

   // ***************************************
   // Scenarios
   // ***************************************
   initial begin
      cyc(10);
      look(8'h40, 8'hFF);
      cyc(10);
      rst <= 1'b0;
      cyc(25);
      look(8'h40, 8'h7F);
      $display("test reset done");
      for (int v = 0; v < 16; v++) begin
         pins(v[3:0]);
         en <= 1'($random(seed));
         cyc(25);
         look(want(v[3:0], en), 8'h7F);
      end
      en <= 1'b1;
      pins(4'hE);
      cyc(25);
      for (int k = 0; k < 2; k++) begin
         pins(k ? 4'hE : 4'hF);
         repeat (12) look(8'h20, 8'h60);
         look(k ? 8'h06 : 8'h0D, 8'h0F);
      end
      pins(4'hD);
      cyc(4);
      look(8'h40, 8'h70);
      cyc(20);
      look(8'h3A, 8'h7F);
      $display("test truth table and discharge done");
      note("status", 32'h3A, 32'h7F);
      bus(1'b0, 4'h4, 32'h0);
      note("ctrl", 32'h1, 32'h3);
      bus(1'b0, 4'h0, 32'h0);
      bus(1'b1, 4'hC, 32'h0);
      note("unmapped", 32'h0, 32'hFFFF_FFFF);
      bus(1'b0, 4'hC, 32'h0);
      bus(1'b1, 4'h0, 32'h0);
      note("ctrl", 32'h0, 32'h1);
      bus(1'b0, 4'h0, 32'h0);
      bus(1'b1, 4'h0, 32'h1);
      $display("test registers done");
      for (int k = 0; k < 2; k++) begin
         pins(k ? 4'hF : 4'h5);
         cyc(25);
         dev_kind <= 2'h1;
         cyc(10);
         look(8'h80, 8'h80);
         pins(4'h6);
         cyc(25);
         look(k ? 8'hB5 : 8'hB2, 8'hF7);
         dev_kind <= 2'h0;
         cyc(2620);
         look(8'h29, 8'hFF);
      end
      pins(4'hD);
      cyc(25);
      dev_kind <= 2'h1;
      cyc(10);
      look(8'h80, 8'h80);
      pins(4'hF);
      cyc(4);
      pins(4'h7);
      look(8'h40, 8'h60);
      dev_kind <= 2'h0;
      cyc(2620);
      look(8'h29, 8'hFF);
      $display("test wake override done");
      pins(4'hF);
      cyc(25);
      dev_kind <= 2'h2;
      cyc(QCYC - 20);
      look(8'h00, 8'h80);
      cyc(40);
      look(8'h80, 8'h80);
      dev_kind <= 2'h0;
      cyc(2620);
      look(8'h00, 8'h80);
      dev_kind <= 2'h3;
      cyc(QCYC + 40);
      look(8'h00, 8'h80);
      $display("test speed recognition done");
      rst <= 1'b1;
      cyc(2);
      look(8'h40, 8'hFF);
      $display("test second reset done");
      finish_test();
   end
endmodule
`default_nettype wire
